/* File: src/wsem_map.svh */
// Constants of the warning status and forward energy meter block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef WSEM_MAP_SVH
`define WSEM_MAP_SVH

// Command codes on the documented command port.
`define WSEM_CODE_INPUT_STATUS 8'h7c
`define WSEM_CODE_AUX_STATUS   8'h80
`define WSEM_CODE_FWD_METER    8'h86

// Bit positions in the input warning status register.
`define WSEM_IN_OV_BIT 6
`define WSEM_IN_UV_BIT 5
`define WSEM_IN_OP_BIT 0
// Bits of the input register that can ever be set.
`define WSEM_IN_LIVE_MASK 8'h61

// Bit positions in the auxiliary warning status register.
`define WSEM_AUX_OV_BIT 6
`define WSEM_AUX_UV_BIT 5
`define WSEM_AUX_LIVE_MASK 8'h60

// Reset values.
`define WSEM_STATUS_RST 8'h00
`define WSEM_ACC_RST    24'h000000
`define WSEM_WRAP_RST   8'h00
`define WSEM_COUNT_RST  24'h000000
`define WSEM_METER_RST  48'h000000000000

// Accumulator masks, one for each variant.
`define WSEM_ACC_MASK_U 24'hffffff
`define WSEM_ACC_MASK_S 24'h7fffff

`endif

/* File: src/wsem_pkg.sv */
// Types of the warning status and forward energy meter block.
// Assumes wsem_map.svh is on the include path.
package wsem_pkg;
  `include "wsem_map.svh"

  typedef struct packed {
    logic [7:0]  in_stat;
    logic [7:0]  aux_stat;
    logic [23:0] fwd_acc;
    logic [7:0]  fwd_wrap;
    logic [23:0] sample_cnt;
    logic [47:0] rsp_data;
    logic        rsp_valid;
    logic        rsp_unsup;
    logic        in_any;
  } wsem_state_t;
endpackage

/* File: src/wsem_core.sv */
// Warning status registers and forward energy meter of a power monitor.
// Assumes threshold comparison outside, one clock, command port decoded
// from the serial bus by a front end that owns byte ordering on the wire.
`timescale 1ns/1ps
`include "wsem_map.svh"

module wsem_core #(
  parameter bit SIGNED_VARIANT = 1'b0
) (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  input  wire logic        PRIMARY_OV_DET,
  input  wire logic        PRIMARY_UV_DET,
  input  wire logic        OVERPOWER_DET,
  input  wire logic        AUX_OV_DET,
  input  wire logic        AUX_UV_DET,
  input  wire logic        WARN_CLEAR,
  input  wire logic        SAMPLE_VALID,
  input  wire logic [15:0] SAMPLE_POWER,
  input  wire logic [15:0] MEASURED_CURRENT,
  input  wire logic        CMD_VALID,
  input  wire logic        CMD_WRITE,
  input  wire logic [7:0]  CMD_CODE,
  output logic      [47:0] READ_DATA,
  output logic             READ_VALID,
  output logic             CMD_UNSUPPORTED,
  output logic             INPUT_STATUS_ANY
);

  wsem_pkg::wsem_state_t st_reg;
  wsem_pkg::wsem_state_t st_next;

  logic        cur_pos;
  logic        cur_neg;
  logic        fwd_add;
  logic        fwd_wraps;
  logic [23:0] acc_sum;
  logic [7:0]  in_set;
  logic [7:0]  aux_set;
  logic        rd_cmd;

  // The signed variant keeps its accumulator inside the positive half.
  localparam logic [23:0] ACC_MASK = SIGNED_VARIANT ? `WSEM_ACC_MASK_S
                                                    : `WSEM_ACC_MASK_U;

  // Adds one sample; the signed variant keeps the count inside the
  // positive half so that the returned word stays a valid two's
  // complement value and wraps from 0x7FFFFF to zero.
  function automatic logic [24:0] accum(input logic [23:0] acc,
                                        input logic [15:0] pwr,
                                        input logic        sgn);
    logic [24:0] s;
    s = {1'b0, acc} + {9'h000, pwr};
    if (sgn) begin
      accum = {s[23], 1'b0, s[22:0]};
    end else begin
      accum = s;
    end
  endfunction

  assign cur_pos = !MEASURED_CURRENT[15] && (MEASURED_CURRENT != 16'h0000);
  assign cur_neg = MEASURED_CURRENT[15];
  assign fwd_add = SAMPLE_VALID && cur_pos;
  assign {fwd_wraps, acc_sum} = accum(st_reg.fwd_acc, SAMPLE_POWER,
                                      SIGNED_VARIANT);
  assign rd_cmd = CMD_VALID && !CMD_WRITE;

  always_comb begin
    in_set = 8'h00;
    aux_set = 8'h00;
    in_set[`WSEM_IN_OV_BIT] = PRIMARY_OV_DET;
    in_set[`WSEM_IN_UV_BIT] = PRIMARY_UV_DET;
    in_set[`WSEM_IN_OP_BIT] = OVERPOWER_DET;
    aux_set[`WSEM_AUX_OV_BIT] = AUX_OV_DET;
    aux_set[`WSEM_AUX_UV_BIT] = AUX_UV_DET;
  end

  always_comb begin
    st_next = st_reg;
    // With the enable low nothing moves, so a one-cycle answer pulse
    // stretches until the enable returns; the host must allow for it.
    if (CE) begin
      st_next.rsp_valid = 1'b0;
      st_next.rsp_unsup = 1'b0;
      // latch until clear, set wins over clear
      st_next.in_stat = ((st_reg.in_stat & {8{!WARN_CLEAR}}) | in_set)
                        & `WSEM_IN_LIVE_MASK;
      st_next.aux_stat = ((st_reg.aux_stat & {8{!WARN_CLEAR}}) | aux_set)
                         & `WSEM_AUX_LIVE_MASK;
      st_next.in_any = |st_next.in_stat;
      if (fwd_add) begin
        st_next.fwd_acc = acc_sum;
        if (fwd_wraps) begin
          st_next.fwd_wrap = st_reg.fwd_wrap + 8'h01;
        end
      end
      if (SAMPLE_VALID && (cur_pos || cur_neg)) begin
        st_next.sample_cnt = st_reg.sample_cnt + 24'h000001;
      end
      // writes change nothing and get no answer.
      if (rd_cmd) begin
        unique case (CMD_CODE)
          `WSEM_CODE_INPUT_STATUS: begin
            st_next.rsp_data = {40'h0000000000, st_reg.in_stat};
            st_next.rsp_valid = 1'b1;
          end
          `WSEM_CODE_AUX_STATUS: begin
            st_next.rsp_data = {40'h0000000000, st_reg.aux_stat};
            st_next.rsp_valid = 1'b1;
          end
          // one-instant snapshot, upper 16 accumulator bits
          `WSEM_CODE_FWD_METER: begin
            st_next.rsp_data = {st_reg.sample_cnt, st_reg.fwd_wrap,
                                st_reg.fwd_acc[23:8]};
            st_next.rsp_valid = 1'b1;
          end
          default: begin
            st_next.rsp_unsup = 1'b1;
          end
        endcase
      end
    end
  end

  // all meter state zero at reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg.in_stat    <= `WSEM_STATUS_RST;
      st_reg.aux_stat   <= `WSEM_STATUS_RST;
      st_reg.fwd_acc    <= `WSEM_ACC_RST;
      st_reg.fwd_wrap   <= `WSEM_WRAP_RST;
      st_reg.sample_cnt <= `WSEM_COUNT_RST;
      st_reg.rsp_data   <= `WSEM_METER_RST;
      st_reg.rsp_valid  <= 1'b0;
      st_reg.rsp_unsup  <= 1'b0;
      st_reg.in_any     <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign READ_DATA        = st_reg.rsp_data;
  assign READ_VALID       = st_reg.rsp_valid;
  assign CMD_UNSUPPORTED  = st_reg.rsp_unsup;
  assign INPUT_STATUS_ANY = st_reg.in_any;

  // Checks below share one clock and drop out while reset is low. All but
  // a_signed_range, which holds on every cycle, fire on the stimulus; each
  // checks state the block drives.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_read_of(logic [7:0] code);
    CE && rd_cmd && (CMD_CODE == code);
  endsequence

  sequence s_fwd_sample;
    CE && fwd_add;
  endsequence

  sequence s_clear_input;
    CE && WARN_CLEAR && (in_set == 8'h00);
  endsequence

  sequence s_clear_aux;
    CE && WARN_CLEAR && (aux_set == 8'h00);
  endsequence

  // Unknown codes answer with a refusal and leave the old data in place.
  sequence s_unknown_read;
    CE && rd_cmd && (CMD_CODE != `WSEM_CODE_INPUT_STATUS)
      && (CMD_CODE != `WSEM_CODE_AUX_STATUS)
      && (CMD_CODE != `WSEM_CODE_FWD_METER);
  endsequence

  a_primary_ov_set: assert property (
    CE && PRIMARY_OV_DET |=> st_reg.in_stat[`WSEM_IN_OV_BIT])
    else $error("Primary overvoltage flag not set.");

  a_primary_uv_set: assert property (
    CE && PRIMARY_UV_DET |=> st_reg.in_stat[`WSEM_IN_UV_BIT])
    else $error("Primary undervoltage flag not set.");

  a_overpower_set: assert property (
    CE && OVERPOWER_DET |=> st_reg.in_stat[`WSEM_IN_OP_BIT])
    else $error("Overpower flag not set.");

  a_input_reserved_zero: assert property (
    s_read_of(`WSEM_CODE_INPUT_STATUS) |=> READ_VALID
      && (READ_DATA & ~{40'h0000000000, `WSEM_IN_LIVE_MASK}) == 48'h0)
    else $error("Input status reserved bits not zero.");

  a_aux_ov_set: assert property (
    CE && AUX_OV_DET |=> st_reg.aux_stat[`WSEM_AUX_OV_BIT])
    else $error("Aux overvoltage flag not set.");

  a_aux_uv_set: assert property (
    CE && AUX_UV_DET |=> st_reg.aux_stat[`WSEM_AUX_UV_BIT])
    else $error("Aux undervoltage flag not set.");

  a_aux_reserved_zero: assert property (
    s_read_of(`WSEM_CODE_AUX_STATUS) |=> READ_VALID
      && (READ_DATA & ~{40'h0000000000, `WSEM_AUX_LIVE_MASK}) == 48'h0)
    else $error("Aux status reserved bits not zero.");

  a_fwd_hold_idle: assert property (
    CE && !fwd_add |=> $stable(st_reg.fwd_acc))
    else $error("Accumulator moved without a positive sample.");

  a_meter_snapshot: assert property (
    s_read_of(`WSEM_CODE_FWD_METER) |=> READ_VALID && READ_DATA ==
      {$past(st_reg.sample_cnt), $past(st_reg.fwd_wrap),
       $past(st_reg.fwd_acc[23:8])})
    else $error("Meter read is not a single-instant snapshot.");

  a_sample_tally: assert property (
    CE && SAMPLE_VALID && (cur_pos || cur_neg) |=>
      st_reg.sample_cnt == $past(st_reg.sample_cnt) + 24'h000001)
    else $error("Sample tally did not advance.");

  a_wrap_count: assert property (
    CE && fwd_add && fwd_wraps |=>
      st_reg.fwd_wrap == $past(st_reg.fwd_wrap) + 8'h01)
    else $error("Wrap counter did not advance on wrap.");

  a_signed_range: assert property (
    SIGNED_VARIANT |-> !st_reg.fwd_acc[23])
    else $error("Signed count left its positive range.");

  a_flag_latched: assert property (
    CE && !WARN_CLEAR && st_reg.in_stat[`WSEM_IN_OV_BIT] |=>
      st_reg.in_stat[`WSEM_IN_OV_BIT])
    else $error("Latched warning dropped without a clear.");

  a_input_any_live: assert property (
    CE ##1 1'b1 |-> INPUT_STATUS_ANY == (|st_reg.in_stat))
    else $error("Input summary bit disagrees with status.");

  a_write_ignored: assert property (
    CE && CMD_VALID && CMD_WRITE |=> !READ_VALID && !CMD_UNSUPPORTED)
    else $error("Write produced an answer.");

  a_aux_ov_latched: assert property (
    CE && !WARN_CLEAR && st_reg.aux_stat[`WSEM_AUX_OV_BIT] |=>
      st_reg.aux_stat[`WSEM_AUX_OV_BIT])
    else $error("Latched aux warning dropped without a clear.");

  a_input_clear: assert property (
    s_clear_input |=> st_reg.in_stat == 8'h00)
    else $error("Input warnings survived a clear.");

  a_aux_clear: assert property (
    s_clear_aux |=> st_reg.aux_stat == 8'h00)
    else $error("Aux warnings survived a clear.");

  a_input_answer: assert property (
    s_read_of(`WSEM_CODE_INPUT_STATUS) |=>
      READ_DATA[7:0] == $past(st_reg.in_stat))
    else $error("Input status answer differs from the register.");

  a_aux_answer: assert property (
    s_read_of(`WSEM_CODE_AUX_STATUS) |=>
      READ_DATA[7:0] == $past(st_reg.aux_stat))
    else $error("Aux status answer differs from the register.");

  a_unknown_read: assert property (
    s_unknown_read |=> CMD_UNSUPPORTED && !READ_VALID
      && $stable(READ_DATA))
    else $error("Unknown read was not refused cleanly.");

  a_idle_quiet: assert property (
    CE && !rd_cmd |=> !READ_VALID && !CMD_UNSUPPORTED)
    else $error("Answer appeared without a read.");

  a_write_keeps: assert property (
    CE && CMD_VALID && CMD_WRITE |=> $stable(READ_DATA))
    else $error("Write disturbed the read data.");

  a_frozen_state: assert property (
    !CE |=> $stable(st_reg))
    else $error("State moved while the clock enable was low.");

  a_fwd_add_value: assert property (
    s_fwd_sample |=> st_reg.fwd_acc ==
      (($past(st_reg.fwd_acc) + {8'h00, $past(SAMPLE_POWER)}) & ACC_MASK))
    else $error("Accumulator did not add the sample.");

  // A sample below the modulus can cross a wrap boundary at most once,
  // so a smaller result after an add means exactly one wrap.
  a_wrap_detect: assert property (
    s_fwd_sample |=> (st_reg.fwd_acc < $past(st_reg.fwd_acc)) ==
      (st_reg.fwd_wrap != $past(st_reg.fwd_wrap)))
    else $error("Wrap counter disagrees with an accumulator wrap.");

  a_wrap_hold: assert property (
    CE && !fwd_add |=> $stable(st_reg.fwd_wrap))
    else $error("Wrap counter moved without a forward sample.");

  // Zero current counts in neither direction, so the tally stays put.
  a_tally_hold: assert property (
    CE && !(SAMPLE_VALID && MEASURED_CURRENT != 16'h0000) |=>
      $stable(st_reg.sample_cnt))
    else $error("Sample tally moved without a signed sample.");

  a_reverse_no_add: assert property (
    CE && SAMPLE_VALID && MEASURED_CURRENT[15] |=> $stable(st_reg.fwd_acc))
    else $error("Negative sample reached the forward accumulator.");

  // The first edge after release still shows the reset values.
  a_reset_zero: assert property (
    $rose(ARST_N) |-> st_reg.fwd_acc == `WSEM_ACC_RST
      && st_reg.fwd_wrap == `WSEM_WRAP_RST
      && st_reg.sample_cnt == `WSEM_COUNT_RST
      && READ_DATA == `WSEM_METER_RST)
    else $error("Meter not cleared by reset.");

  a_any_follows: assert property (
    CE && (in_set != 8'h00) |=> INPUT_STATUS_ANY)
    else $error("Input summary bit missed a new warning.");

endmodule

/* File: tb/wsem_host.sv */
// Host model that issues command requests to the status block.
// Assumes one clock; requests launch just after a rising edge.
`timescale 1ns/1ps
module wsem_host (
  input  wire logic        clk,
  input  wire logic [47:0] rd_data,
  input  wire logic        rd_valid,
  input  wire logic        unsup,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code
);
  logic [47:0] rsp;
  logic        ok;
  logic        bad;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
  end
  // Released code lines show the inverse, so a stale value never matches.
  task automatic xfer(input logic wr, input logic [7:0] code);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code  <= code;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code  <= ~code;
    #1;
    rsp = rd_data;
    ok  = rd_valid;
    bad = unsup;
  endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the warning status and energy meter block.
// Assumes the host model owns the command port.
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        arst_n;
  logic        ce;
  logic [4:0]  det;
  logic        clr;
  logic        sv;
  logic [15:0] pw;
  logic [15:0] cur;
  logic        cv;
  logic        cw;
  logic [7:0]  cc;
  logic [47:0] rd;
  logic        rv;
  logic        un;
  logic        any;
  logic [47:0] rd_s;
  logic        rv_s;
  logic        un_s;
  logic        any_s;
  int          num_errors;
  int          samples_checked;
  int          cycles;
  logic [7:0]  in_tab [5] = '{8'h40, 8'h60, 8'h61, 8'h61, 8'h61};
  logic [7:0]  aux_tab [5] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h60};
  logic [47:0] snap;

  wsem_core i_dut (
    .CLK(clk), .ARST_N(arst_n), .CE(ce),
    .PRIMARY_OV_DET(det[0]), .PRIMARY_UV_DET(det[1]),
    .OVERPOWER_DET(det[2]), .AUX_OV_DET(det[3]), .AUX_UV_DET(det[4]),
    .WARN_CLEAR(clr), .SAMPLE_VALID(sv), .SAMPLE_POWER(pw),
    .MEASURED_CURRENT(cur), .CMD_VALID(cv), .CMD_WRITE(cw),
    .CMD_CODE(cc), .READ_DATA(rd), .READ_VALID(rv),
    .CMD_UNSUPPORTED(un), .INPUT_STATUS_ANY(any)
  );
  wsem_core #(
    .SIGNED_VARIANT(1'b1)
  ) i_dut_sgn (
    .CLK(clk), .ARST_N(arst_n), .CE(ce),
    .PRIMARY_OV_DET(det[0]), .PRIMARY_UV_DET(det[1]),
    .OVERPOWER_DET(det[2]), .AUX_OV_DET(det[3]), .AUX_UV_DET(det[4]),
    .WARN_CLEAR(clr), .SAMPLE_VALID(sv), .SAMPLE_POWER(pw),
    .MEASURED_CURRENT(cur), .CMD_VALID(cv), .CMD_WRITE(cw),
    .CMD_CODE(cc), .READ_DATA(rd_s), .READ_VALID(rv_s),
    .CMD_UNSUPPORTED(un_s), .INPUT_STATUS_ANY(any_s)
  );
  wsem_host i_host (
    .clk(clk), .rd_data(rd), .rd_valid(rv), .unsup(un),
    .cmd_valid(cv), .cmd_write(cw), .cmd_code(cc)
  );

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] code, input logic [47:0] exp);
    i_host.xfer(1'b0, code);
    chk({46'h0, i_host.bad, i_host.ok}, 48'h1);
    chk(i_host.rsp, exp);
  endtask
  task automatic feed(input int n, input logic [15:0] p,
                      input logic [15:0] c);
    repeat (n) begin
      @(posedge clk);
      sv  <= 1'b1;
      pw  <= p;
      cur <= c;
    end
    @(posedge clk);
    sv <= 1'b0;
  endtask
  task final_report;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The full sequence takes well under a thousand cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      final_report;
    end
  end

  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    det = 5'h00;
    clr = 1'b0;
    sv = 1'b0;
    pw = 16'h0000;
    cur = 16'h0000;
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(8'h86, 48'h0);
    rd_chk(8'h80, 48'h0);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      det[i] <= 1'b1;
      @(posedge clk);
      det <= 5'h00;
      rd_chk(8'h7c, {40'h0, in_tab[i]});
      rd_chk(8'h80, {40'h0, aux_tab[i]});
      chk({46'h0, any_s, any}, 48'h3);
    end
    i_host.xfer(1'b1, 8'h7c);
    chk({46'h0, i_host.bad, i_host.ok}, 48'h0);
    rd_chk(8'h7c, 48'h61);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    rd_chk(8'h7c, 48'h0);
    rd_chk(8'h80, 48'h0);
    chk({46'h0, any_s, any}, 48'h0);
    feed(257, 16'hffff, 16'h0001);
    feed(3, 16'h1234, 16'h8000);
    feed(1, 16'h1234, 16'h0000);
    snap = {24'd260, 8'h01, 16'h00fe};
    // A sample landing on the read edge must not leak into the answer.
    fork
      rd_chk(8'h86, snap);
      feed(1, 16'h0100, 16'h0001);
    join
    chk(rd_s, {24'd260, 8'h02, 16'h00fe});
    chk({46'h0, un_s, rv_s}, 48'h1);
    snap = {24'd261, 8'h01, 16'h00ff};
    rd_chk(8'h86, snap);
    chk(rd_s, {24'd261, 8'h02, 16'h00ff});
    i_host.xfer(1'b1, 8'h86);
    rd_chk(8'h86, snap);
    i_host.xfer(1'b0, 8'h87);
    chk({46'h0, i_host.bad, i_host.ok}, 48'h2);
    chk(i_host.rsp, snap);
    chk({46'h0, un_s, rv_s}, 48'h2);
    // With the enable low, warnings, samples and reads must all be lost.
    @(posedge clk);
    ce  <= 1'b0;
    det <= 5'h1f;
    feed(2, 16'h4000, 16'h0001);
    i_host.xfer(1'b0, 8'h7c);
    chk({46'h0, i_host.bad, i_host.ok}, 48'h0);
    @(posedge clk);
    ce  <= 1'b1;
    det <= 5'h00;
    rd_chk(8'h7c, 48'h0);
    rd_chk(8'h86, snap);
    chk(rd_s, {24'd261, 8'h02, 16'h00ff});
    // A reset in mid-run must bring the meter back to zero.
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(8'h86, 48'h0);
    chk(rd_s, 48'h0);
    final_report;
  end
endmodule
